/* File: rtl/pma_regs_map.svh */
// Address map, field positions, reset values and frame counts of the PMA register bank
`ifndef PMA_REGS_MAP_SVH
`define PMA_REGS_MAP_SVH

`define DEVAD_PMA      5'h01
`define DEVAD_VND      5'h1E

`define REG_CTRL       16'h0000
`define REG_STAT       16'h0001
`define REG_STAT2      16'h0008
`define REG_RSV_A      16'h8030
`define REG_FAST_STAT  16'h8033
`define REG_SLOW_STAT  16'h8034
`define REG_RSV_STAT   16'h8035
`define REG_RSV_B      16'h8100
`define REG_RSV_C      16'h8101
`define REG_DBG        16'h9000

`define CTRL_RST_BIT   15
`define CTRL_PWR_BIT   11
`define CTRL_LPB_BIT   0
`define STAT_FLT_BIT   7
`define STAT_LNK_BIT   2
`define STAT_LP_BIT    1
`define STAT_RESET     16'h0002

`define MASK_RSV_A     16'h000F
`define MASK_RSV_B     16'h07FF
`define MASK_RSV_C     16'h3FFF
`define MASK_DBG       16'h0F31

`define FAST_TX_RATE   9:8
`define FAST_RX_RATE   6:4
`define FAST_PLL_MULT  3:0
`define SLOW_TX_RATE   9:8
`define SLOW_RX_RATE   5:4
`define SLOW_PLL_MULT  3:0

`define OP_ADDR        2'b00
`define OP_WRITE       2'b01
`define OP_READ        2'b11
`define OP_READ_INC    2'b10
`define ST_CL45        2'b00

`define PREAMBLE_LEN   6'h20
`define FRAME_HDR      6'h0E
`define FRAME_TA2      6'h0F
`define FRAME_DATA     6'h10
`define FRAME_END      6'h20

`endif

/* File: rtl/pma_regs_pkg.sv */
// Types used by the management frame engine inside the PMA register bank
package pma_regs_pkg;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_HDR  = 3'b010,
		PH_BODY = 3'b100
	} mdio_phase_e;

	typedef struct packed {
		mdio_phase_e phase;
		logic        mdc_q;
		logic [5:0]  ones;
		logic [5:0]  cnt;
		logic [31:0] sh;
		logic [11:0] hdr;
		logic [15:0] tx;
		logic        drive;
		logic        oe;
		logic        out;
		logic        cmd;
		logic        rd_req;
	} mdio_eng_s;

endpackage : pma_regs_pkg

/* File: rtl/mdio_frame_engine.sv */
// Clause 45 serial frame receiver and read-data driver on the management pins
`timescale 1ns/1ps
`default_nettype none
`include "pma_regs_map.svh"

module mdio_frame_engine (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        ce,
	input  wire logic        mdc,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe,
	output logic [1:0]       op,
	output logic [4:0]       prtad,
	output logic [4:0]       devad,
	output logic [15:0]      wdata,
	output logic             cmd,
	output logic             rd_req,
	input  wire logic        hit,
	input  wire logic [15:0] rd_data
);

	pma_regs_pkg::mdio_eng_s s_r;
	pma_regs_pkg::mdio_eng_s s_nxt;
	logic [31:0]             sh_in;
	logic [5:0]              cnt_in;

	assign op       = s_r.hdr[11:10];
	assign prtad    = s_r.hdr[9:5];
	assign devad    = s_r.hdr[4:0];
	assign wdata    = s_r.sh[15:0];
	assign cmd      = s_r.cmd;
	assign rd_req   = s_r.rd_req;
	assign mdio_out = s_r.out;
	assign mdio_oe  = s_r.oe;
	assign sh_in    = {s_r.sh[30:0], mdio_in};
	assign cnt_in   = s_r.cnt + 6'h01;

	always_comb begin
		s_nxt        = s_r;
		s_nxt.mdc_q  = mdc;
		s_nxt.cmd    = 1'b0;
		s_nxt.rd_req = 1'b0;
		// Read word and ownership are fixed in the cycle after the header
		if (s_r.rd_req) begin
			s_nxt.drive = hit;
			s_nxt.tx    = rd_data;
		end
		if (mdc && !s_r.mdc_q) begin
			case (s_r.phase)
				pma_regs_pkg::PH_IDLE: begin
					if (mdio_in) begin
						if (s_r.ones != `PREAMBLE_LEN)
							s_nxt.ones = s_r.ones + 6'h01;
					end else begin
						s_nxt.ones = 6'h00;
						if (s_r.ones == `PREAMBLE_LEN) begin
							s_nxt.phase = pma_regs_pkg::PH_HDR;
							s_nxt.cnt   = 6'h01;
							s_nxt.sh    = 32'h0000_0000;
						end
					end
				end
				pma_regs_pkg::PH_HDR: begin
					s_nxt.sh  = sh_in;
					s_nxt.cnt = cnt_in;
					if (cnt_in == `FRAME_HDR) begin
						s_nxt.hdr = sh_in[11:0];
						if (sh_in[13:12] != `ST_CL45) begin
							s_nxt.phase = pma_regs_pkg::PH_IDLE;
						end else begin
							s_nxt.phase  = pma_regs_pkg::PH_BODY;
							s_nxt.drive  = 1'b0;
							s_nxt.rd_req = sh_in[11];
						end
					end
				end
				pma_regs_pkg::PH_BODY: begin
					s_nxt.sh  = sh_in;
					s_nxt.cnt = cnt_in;
					if (s_r.hdr[11] && s_r.drive) begin
						if (cnt_in == `FRAME_TA2) begin
							s_nxt.oe  = 1'b1;
							s_nxt.out = 1'b0;
						end else if (cnt_in >= `FRAME_DATA && cnt_in != `FRAME_END) begin
							s_nxt.out = s_r.tx[15];
							s_nxt.tx  = {s_r.tx[14:0], 1'b0};
						end
					end
					if (cnt_in == `FRAME_END) begin
						s_nxt.phase = pma_regs_pkg::PH_IDLE;
						s_nxt.oe    = 1'b0;
						s_nxt.out   = 1'b0;
						s_nxt.drive = 1'b0;
						s_nxt.cmd   = !s_r.hdr[11];
					end
				end
				default: s_nxt.phase = pma_regs_pkg::PH_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_r       <= '0;
			s_r.phase <= pma_regs_pkg::PH_IDLE;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

endmodule : mdio_frame_engine

`default_nettype wire

/* File: rtl/pma_control_status_registers.sv */
// PMA/PMD control, status and vendor register bank behind the Clause 45 pins
// Functional notes
// [RULE1] Writing 1 to control bit 15 resets all channels' registers and self-clears to 0.
// [RULE2] Control bit 11 requests power down for the addressed channel and resets to 0.
// [RULE3] Control bit 0 enables the fast-side serial loopback for the channel and resets to 0.
// [RULE4] Status bit 7 holds 1 after a fault until register 1.8 is read with no fault since.
// [RULE5] Status bit 2 shows receive link up and latches low.
// [RULE6] A latched-low link bit stays 0 until the status register is read, then follows the link.
// [RULE7] Status bit 1 always reads 1 and the status word resets to 0x0002.
// [RULE8] The station manager reaches the PMA group only with device address one.
// [RULE9] The debug word at 0x9000 is one register shared by every channel.
// [RULE10] Fast-side status: tx rate 9:8, rx rate 6:4, PLL multiplier 3:0, read-only, resets 0.
// [RULE11] The slow-side status word reports tx rate 9:8, rx rate 5:4 and PLL multiplier 3:0.
// [RULE12] Vendor control words 0x8100 and 0x8101 are read/write and reset to zero.
// [RULE13] The station manager reaches the vendor debug set with device address 0x1E.
`timescale 1ns/1ps
`default_nettype none
`include "pma_regs_map.svh"

module pma_control_status_registers #(
	parameter int         NCH       = 4,
	parameter logic [4:0] PORT_BASE = 5'h00
) (
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic             ce,
	input  wire logic             mdc,
	input  wire logic             mdio_in,
	output logic                  mdio_out,
	output logic                  mdio_oe,
	input  wire logic [NCH-1:0]   link_up,
	input  wire logic [NCH-1:0]   fault_detect,
	input  wire logic [2*NCH-1:0] fast_side_tx_rate_result,
	input  wire logic [3*NCH-1:0] fast_side_rx_rate_result,
	input  wire logic [4*NCH-1:0] fast_side_pll_mult_result,
	input  wire logic [2*NCH-1:0] slow_side_tx_rate_result,
	input  wire logic [2*NCH-1:0] slow_side_rx_rate_result,
	input  wire logic [4*NCH-1:0] slow_side_pll_mult_result,
	output logic [NCH-1:0]        power_off_request,
	output logic [NCH-1:0]        loopback_enable,
	output logic                  global_reset
);

	localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

	typedef struct packed {
		logic [15:0]           addr_pma;
		logic [15:0]           addr_vnd;
		logic [NCH-1:0]        pwr;
		logic [NCH-1:0]        lpb;
		logic [NCH-1:0]        link;
		logic [NCH-1:0]        fault;
		logic [NCH-1:0][15:0]  rsv_a;
		logic [NCH-1:0][15:0]  rsv_b;
		logic [NCH-1:0][15:0]  rsv_c;
		logic [NCH-1:0][15:0]  fast;
		logic [NCH-1:0][15:0]  slow;
		logic [15:0]           dbg;
		logic                  grst;
	} regs_s;

	regs_s                s_r;
	regs_s                s_nxt;
	logic [1:0]           op;
	logic [4:0]           prtad;
	logic [4:0]           devad;
	logic [15:0]          wdata;
	logic                 cmd;
	logic                 rd_req;
	logic                 hit;
	logic [15:0]          rd_data;
	logic [4:0]           chan_off;
	logic [CW-1:0]        chan;
	logic [15:0]          cur_addr;
	logic                 wr_ev;
	logic                 rd_ev;
	logic [NCH-1:0][15:0] fast_word;
	logic [NCH-1:0][15:0] slow_word;

	function automatic logic at_reg(input logic [4:0] dv, input logic [15:0] ad,
			input logic [4:0] want_dv, input logic [15:0] want_ad);
		at_reg = (dv == want_dv) && (ad == want_ad);
	endfunction : at_reg

	function automatic logic [15:0] pack_fast(input logic [1:0] tx, input logic [2:0] rx,
			input logic [3:0] pm);
		pack_fast                 = 16'h0000;
		pack_fast[`FAST_TX_RATE]  = tx;
		pack_fast[`FAST_RX_RATE]  = rx;
		pack_fast[`FAST_PLL_MULT] = pm;
	endfunction : pack_fast

	function automatic logic [15:0] pack_slow(input logic [1:0] tx, input logic [1:0] rx,
			input logic [3:0] pm);
		pack_slow                 = 16'h0000;
		pack_slow[`SLOW_TX_RATE]  = tx;
		pack_slow[`SLOW_RX_RATE]  = rx;
		pack_slow[`SLOW_PLL_MULT] = pm;
	endfunction : pack_slow

	mdio_frame_engine u_engine (
		.clk_sys (clk_sys),
		.srst    (srst),
		.ce      (ce),
		.mdc     (mdc),
		.mdio_in (mdio_in),
		.mdio_out(mdio_out),
		.mdio_oe (mdio_oe),
		.op      (op),
		.prtad   (prtad),
		.devad   (devad),
		.wdata   (wdata),
		.cmd     (cmd),
		.rd_req  (rd_req),
		.hit     (hit),
		.rd_data (rd_data)
	);

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_stat
			assign fast_word[g] = pack_fast(fast_side_tx_rate_result[2*g +: 2],
				fast_side_rx_rate_result[3*g +: 3], fast_side_pll_mult_result[4*g +: 4]); // [RULE10]
			assign slow_word[g] = pack_slow(slow_side_tx_rate_result[2*g +: 2],
				slow_side_rx_rate_result[2*g +: 2], slow_side_pll_mult_result[4*g +: 4]); // [RULE11]
		end
	endgenerate

	// Only device addresses one and 0x1E on one of our ports are answered
	assign chan_off = prtad - PORT_BASE;
	assign chan     = chan_off[CW-1:0];
	assign hit      = (32'(chan_off) < NCH)
		&& (devad == `DEVAD_PMA || devad == `DEVAD_VND); // [RULE8] [RULE13]
	assign cur_addr = (devad == `DEVAD_PMA) ? s_r.addr_pma : s_r.addr_vnd;
	assign wr_ev    = cmd && hit && (op == `OP_WRITE);
	assign rd_ev    = rd_req && hit;

	always_comb begin
		rd_data = 16'h0000;
		if (at_reg(devad, cur_addr, `DEVAD_PMA, `REG_CTRL)) begin
			rd_data[`CTRL_PWR_BIT] = s_r.pwr[chan];
			rd_data[`CTRL_LPB_BIT] = s_r.lpb[chan];
		end else if (at_reg(devad, cur_addr, `DEVAD_PMA, `REG_STAT)) begin
			rd_data                = `STAT_RESET; // [RULE7]
			rd_data[`STAT_FLT_BIT] = s_r.fault[chan]; // [RULE4]
			rd_data[`STAT_LNK_BIT] = s_r.link[chan]; // [RULE5]
		end else if (at_reg(devad, cur_addr, `DEVAD_VND, `REG_RSV_A)) begin
			rd_data = s_r.rsv_a[chan];
		end else if (at_reg(devad, cur_addr, `DEVAD_VND, `REG_FAST_STAT)) begin
			rd_data = s_r.fast[chan]; // [RULE10]
		end else if (at_reg(devad, cur_addr, `DEVAD_VND, `REG_SLOW_STAT)) begin
			rd_data = s_r.slow[chan]; // [RULE11]
		end else if (at_reg(devad, cur_addr, `DEVAD_VND, `REG_RSV_B)) begin
			rd_data = s_r.rsv_b[chan]; // [RULE12]
		end else if (at_reg(devad, cur_addr, `DEVAD_VND, `REG_RSV_C)) begin
			rd_data = s_r.rsv_c[chan]; // [RULE12]
		end else if (at_reg(devad, cur_addr, `DEVAD_VND, `REG_DBG)) begin
			rd_data = s_r.dbg; // [RULE9]
		end
	end

	always_comb begin
		s_nxt      = s_r;
		s_nxt.grst = 1'b0;
		s_nxt.fast = fast_word;
		s_nxt.slow = slow_word;
		for (int i = 0; i < NCH; i++) begin
			s_nxt.link[i]  = s_r.link[i] & link_up[i]; // [RULE5]
			s_nxt.fault[i] = s_r.fault[i] | fault_detect[i]; // [RULE4]
		end
		if (rd_ev) begin
			if (at_reg(devad, cur_addr, `DEVAD_PMA, `REG_STAT))
				s_nxt.link[chan] = link_up[chan]; // [RULE6]
			if (at_reg(devad, cur_addr, `DEVAD_PMA, `REG_STAT2))
				s_nxt.fault[chan] = fault_detect[chan]; // [RULE4]
			if (op == `OP_READ_INC) begin
				if (devad == `DEVAD_PMA)
					s_nxt.addr_pma = s_r.addr_pma + 16'h0001;
				else
					s_nxt.addr_vnd = s_r.addr_vnd + 16'h0001;
			end
		end
		if (cmd && hit && op == `OP_ADDR) begin
			if (devad == `DEVAD_PMA)
				s_nxt.addr_pma = wdata;
			else
				s_nxt.addr_vnd = wdata;
		end
		if (wr_ev) begin
			if (at_reg(devad, cur_addr, `DEVAD_PMA, `REG_CTRL)) begin
				s_nxt.pwr[chan] = wdata[`CTRL_PWR_BIT]; // [RULE2]
				s_nxt.lpb[chan] = wdata[`CTRL_LPB_BIT]; // [RULE3]
			end
			if (at_reg(devad, cur_addr, `DEVAD_VND, `REG_RSV_A))
				s_nxt.rsv_a[chan] = wdata & `MASK_RSV_A;
			if (at_reg(devad, cur_addr, `DEVAD_VND, `REG_RSV_B))
				s_nxt.rsv_b[chan] = wdata & `MASK_RSV_B; // [RULE12]
			if (at_reg(devad, cur_addr, `DEVAD_VND, `REG_RSV_C))
				s_nxt.rsv_c[chan] = wdata & `MASK_RSV_C; // [RULE12]
			if (at_reg(devad, cur_addr, `DEVAD_VND, `REG_DBG))
				s_nxt.dbg = wdata & `MASK_DBG; // [RULE9]
			// Global reset clears every channel and keeps the address pointers
			if (at_reg(devad, cur_addr, `DEVAD_PMA, `REG_CTRL) && wdata[`CTRL_RST_BIT]) begin
				s_nxt          = '0; // [RULE1]
				s_nxt.addr_pma = s_r.addr_pma;
				s_nxt.addr_vnd = s_r.addr_vnd;
				s_nxt.grst     = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign power_off_request = s_r.pwr;
	assign loopback_enable   = s_r.lpb;
	assign global_reset      = s_r.grst;

	logic ctrl_wr;
	logic rd_stat2_0;
	assign ctrl_wr    = wr_ev && ce && at_reg(devad, cur_addr, `DEVAD_PMA, `REG_CTRL);
	assign rd_stat2_0 = rd_ev && chan == '0 && at_reg(devad, cur_addr, `DEVAD_PMA, `REG_STAT2);

	grst_pulse_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE1]
		ctrl_wr && wdata[`CTRL_RST_BIT] |=> global_reset && power_off_request == '0
			&& loopback_enable == '0 ##1 (!global_reset || $past(ctrl_wr)))
		else $error("global reset not a clean pulse with cleared controls");
	pwr_write_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE2]
		ctrl_wr && !wdata[`CTRL_RST_BIT] |=> power_off_request[$past(chan)]
			== $past(wdata[`CTRL_PWR_BIT]))
		else $error("power down bit did not take the written value");
	loopback_write_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE3]
		ctrl_wr && !wdata[`CTRL_RST_BIT] |=> loopback_enable[$past(chan)]
			== $past(wdata[`CTRL_LPB_BIT]))
		else $error("loopback bit did not take the written value");
	fault_hold_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE4]
		ce && (fault_detect[0] || (s_r.fault[0] && !rd_stat2_0)) && !s_nxt.grst
			|=> s_r.fault[0])
		else $error("fault flag dropped without a status-2 read");
	link_latch_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE5]
		ce && !link_up[0] |=> !s_r.link[0])
		else $error("link bit did not latch low");
	link_follow_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE6]
		ce && rd_ev && chan == '0 && at_reg(devad, cur_addr, `DEVAD_PMA, `REG_STAT)
			&& link_up[0] && !s_nxt.grst |=> s_r.link[0])
		else $error("link bit did not follow the link after a read");
	low_power_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE7]
		rd_ev && at_reg(devad, cur_addr, `DEVAD_PMA, `REG_STAT)
			|-> rd_data[`STAT_LP_BIT] && rd_data[15:8] == 8'h00)
		else $error("status word low_power_capable wrong");
	debug_shared_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE9]
		wr_ev && ce && at_reg(devad, cur_addr, `DEVAD_VND, `REG_DBG)
			|=> s_r.dbg == ($past(wdata) & `MASK_DBG))
		else $error("shared debug word not updated");
	fast_status_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE10]
		ce && !(ctrl_wr && wdata[`CTRL_RST_BIT])
			|=> s_r.fast[0][`FAST_RX_RATE] == $past(fast_side_rx_rate_result[2:0])
			&& s_r.fast[0][15:10] == 6'h00 && s_r.fast[0][7] == 1'b0)
		else $error("fast side status word wrong");
	rsv_write_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE12]
		wr_ev && ce && at_reg(devad, cur_addr, `DEVAD_VND, `REG_RSV_B)
			|=> s_r.rsv_b[$past(chan)] == ($past(wdata) & `MASK_RSV_B))
		else $error("vendor control word not written");

	reset_cmd_c: cover property (@(posedge clk_sys) ctrl_wr && wdata[`CTRL_RST_BIT]);
	stat_read_c: cover property (@(posedge clk_sys)
		rd_ev && at_reg(devad, cur_addr, `DEVAD_PMA, `REG_STAT) && !s_r.link[0]);
	dbg_read_c: cover property (@(posedge clk_sys)
		rd_ev && at_reg(devad, cur_addr, `DEVAD_VND, `REG_DBG) && chan != '0);

endmodule : pma_control_status_registers

`default_nettype wire

/* File: verification/mdio_station.sv */
// Station manager model: drives Clause 45 frames on mdc/mdio and samples read data
`timescale 1ns/1ps
`default_nettype none
`include "pma_regs_map.svh"

module mdio_station (
	input  wire logic clk_sys,
	input  wire logic mdio_wire,
	output var logic  mdc,
	output var logic  sta_out,
	output var logic  sta_oe
);
	initial begin
		mdc = 1'b0;
		sta_out = 1'b1;
		sta_oe = 1'b0;
	end

	// Drive during the low phase, sample the wire as mdc rises; two clocks per phase
	task automatic bit_cycle(input logic drv, input logic val, output logic seen);
		mdc = 1'b0;
		sta_oe = drv;
		sta_out = val;
		repeat (2) @(negedge clk_sys);
		mdc = 1'b1;
		seen = mdio_wire;
		repeat (2) @(negedge clk_sys);
	endtask : bit_cycle

	task automatic frame(input logic [1:0] op, input logic [4:0] prt, input logic [4:0] dev,
			input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] w;
		logic        s;
		w = {`ST_CL45, op, prt, dev, 2'b10, wd};
		for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
		// Reads release the line after the header so the device owns turnaround and data
		for (int i = 31; i >= 0; i--) begin
			bit_cycle(op[1] ? (i > 17) : 1'b1, w[i], s);
			if (i < 16) rd[i] = s;
		end
		mdc = 1'b0;
		sta_oe = 1'b0;
		repeat (4) @(negedge clk_sys);
	endtask : frame

	task automatic access(input logic [4:0] dev, input logic [4:0] prt, input logic [15:0] ad,
			input logic wr, input logic [15:0] wd, output logic [15:0] rd);
		logic [15:0] x;
		frame(`OP_ADDR, prt, dev, ad, x);
		frame(wr ? `OP_WRITE : `OP_READ, prt, dev, wd, rd);
	endtask : access

	task automatic reach(input logic vnd, input logic [4:0] prt, input logic [15:0] ad,
			input logic wr, input logic [15:0] wd, output logic [15:0] rd);
		if (vnd) access(`DEVAD_VND, prt, ad, wr, wd, rd);
		else access(`DEVAD_PMA, prt, ad, wr, wd, rd);
	endtask : reach
endmodule : mdio_station
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the PMA register bank driven through the station model
`timescale 1ns/1ps
`default_nettype none
`include "pma_regs_map.svh"

module tb_top;
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic        ce = 1'b1;
	logic        mdc;
	logic        mdio_out;
	logic        mdio_oe;
	logic        sta_out;
	logic        sta_oe;
	wire         mdio_wire;
	logic [3:0]  link_up = 4'h0;
	logic [3:0]  fault_detect = 4'h0;
	logic [7:0]  ftx = 8'h00;
	logic [11:0] frx = 12'h000;
	logic [15:0] fpm = 16'h0000;
	logic [7:0]  stx = 8'h00;
	logic [7:0]  srx = 8'h00;
	logic [15:0] spm = 16'h0000;
	logic [3:0]  pwr;
	logic [3:0]  lpb;
	logic        global_reset;
	int          gr_cnt = 0;
	int          error_cnt = 0;
	int          samples_checked = 0;

	// Tri-state style wire, device before station, with a pull-up when nobody drives
	assign mdio_wire = mdio_oe ? mdio_out : (sta_oe ? sta_out : 1'b1);

	always #2.5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) if (global_reset === 1'b1) gr_cnt <= gr_cnt + 1;

	pma_control_status_registers #(.NCH(4), .PORT_BASE(5'h00)) pma_control_status_registers_i (
		.clk_sys(clk_sys), .srst(srst), .ce(ce), .mdc(mdc), .mdio_in(mdio_wire),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .link_up(link_up), .fault_detect(fault_detect),
		.fast_side_tx_rate_result(ftx), .fast_side_rx_rate_result(frx),
		.fast_side_pll_mult_result(fpm), .slow_side_tx_rate_result(stx),
		.slow_side_rx_rate_result(srx), .slow_side_pll_mult_result(spm),
		.power_off_request(pwr), .loopback_enable(lpb), .global_reset(global_reset));

	mdio_station mdio_station_i (.clk_sys(clk_sys), .mdio_wire(mdio_wire), .mdc(mdc),
		.sta_out(sta_out), .sta_oe(sta_oe));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic put(input logic vnd, input logic [4:0] prt, input logic [15:0] ad,
			input logic [15:0] wd);
		logic [15:0] x;
		mdio_station_i.reach(vnd, prt, ad, 1'b1, wd, x);
	endtask : put

	task automatic expect_reg(input logic vnd, input logic [4:0] prt, input logic [15:0] ad,
			input logic [15:0] exp, input string what);
		logic [15:0] v;
		mdio_station_i.reach(vnd, prt, ad, 1'b0, 16'h0000, v);
		check(what, v, exp);
	endtask : expect_reg

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict

	task automatic reset_values;
		expect_reg(1'b0, 5'd0, `REG_CTRL, 16'h0000, "ctrl");
		expect_reg(1'b0, 5'd3, `REG_STAT, `STAT_RESET, "stat");
		expect_reg(1'b1, 5'd0, `REG_RSV_B, 16'h0000, "rsv_b");
		expect_reg(1'b1, 5'd1, `REG_RSV_C, 16'h0000, "rsv_c");
		expect_reg(1'b1, 5'd2, `REG_FAST_STAT, 16'h0000, "fast");
	endtask : reset_values

	task automatic control_bits;
		put(1'b0, 5'd1, `REG_CTRL, 16'h0801);
		put(1'b0, 5'd2, `REG_CTRL, 16'h0800);
		check("pwr", {12'h000, pwr}, 16'h0006);
		check("lpb", {12'h000, lpb}, 16'h0002);
		expect_reg(1'b0, 5'd1, `REG_CTRL, 16'h0801, "ctrl1");
		put(1'b1, 5'd3, `REG_RSV_B, 16'h0123);
		put(1'b0, 5'd1, `REG_CTRL, 16'h8000);
		check("gr", gr_cnt[15:0], 16'h0001);
		check("pwr0", {12'h000, pwr}, 16'h0000);
		expect_reg(1'b0, 5'd1, `REG_CTRL, 16'h0000, "ctrl_sc");
		expect_reg(1'b1, 5'd3, `REG_RSV_B, 16'h0000, "rsv_rst");
	endtask : control_bits

	task automatic link_latch;
		logic [15:0] x;
		@(negedge clk_sys);
		link_up = 4'hF;
		mdio_station_i.reach(1'b0, 5'd0, `REG_STAT, 1'b0, 16'h0000, x);
		expect_reg(1'b0, 5'd0, `REG_STAT, 16'h0006, "lnk_up");
		link_up[0] = 1'b0;
		repeat (3) @(negedge clk_sys);
		link_up[0] = 1'b1;
		expect_reg(1'b0, 5'd0, `REG_STAT, 16'h0002, "lnk_ll");
		expect_reg(1'b0, 5'd0, `REG_STAT, 16'h0006, "lnk_rearm");
	endtask : link_latch

	task automatic fault_flag;
		fault_detect[0] = 1'b1;
		expect_reg(1'b0, 5'd0, `REG_STAT2, 16'h0000, "stat2");
		fault_detect[0] = 1'b0;
		expect_reg(1'b0, 5'd0, `REG_STAT, 16'h0086, "flt_hold");
		expect_reg(1'b0, 5'd0, `REG_STAT, 16'h0086, "flt_hold2");
		expect_reg(1'b0, 5'd0, `REG_STAT2, 16'h0000, "stat2b");
		expect_reg(1'b0, 5'd0, `REG_STAT, 16'h0006, "flt_clr");
	endtask : fault_flag

	// A link drop while the clock enable is low must not reach the latch
	task automatic ce_freeze;
		@(negedge clk_sys);
		ce = 1'b0;
		link_up[0] = 1'b0;
		repeat (4) @(negedge clk_sys);
		link_up[0] = 1'b1;
		@(negedge clk_sys);
		ce = 1'b1;
		expect_reg(1'b0, 5'd0, `REG_STAT, 16'h0006, "ce_hold");
	endtask : ce_freeze

	task automatic rate_words;
		@(negedge clk_sys);
		ftx = 8'h30;
		frx = 12'h140;
		fpm = 16'h0A00;
		stx = 8'h10;
		srx = 8'h20;
		spm = 16'h0700;
		expect_reg(1'b1, 5'd2, `REG_FAST_STAT, 16'h035A, "fast2");
		expect_reg(1'b1, 5'd1, `REG_FAST_STAT, 16'h0000, "fast1");
		expect_reg(1'b1, 5'd2, `REG_SLOW_STAT, 16'h0127, "slow2");
		put(1'b1, 5'd2, `REG_FAST_STAT, 16'hFFFF);
		expect_reg(1'b1, 5'd2, `REG_FAST_STAT, 16'h035A, "fast_ro");
	endtask : rate_words

	task automatic vendor_words;
		put(1'b1, 5'd0, `REG_RSV_B, 16'hFFFF);
		expect_reg(1'b1, 5'd0, `REG_RSV_B, 16'h07FF, "rsv_b0");
		expect_reg(1'b1, 5'd3, `REG_RSV_B, 16'h0000, "rsv_b3");
		put(1'b1, 5'd0, `REG_RSV_C, 16'hFFFF);
		expect_reg(1'b1, 5'd0, `REG_RSV_C, 16'h3FFF, "rsv_c0");
		put(1'b1, 5'd0, `REG_DBG, 16'hFFFF);
		expect_reg(1'b1, 5'd3, `REG_DBG, 16'h0F31, "dbg3");
		put(1'b1, 5'd2, `REG_DBG, 16'h0001);
		expect_reg(1'b1, 5'd1, `REG_DBG, 16'h0001, "dbg1");
	endtask : vendor_words

	task automatic refused;
		logic [15:0] v;
		mdio_station_i.access(5'h03, 5'd0, `REG_CTRL, 1'b0, 16'h0000, v);
		check("bad_dev", v, 16'hFFFF);
		mdio_station_i.access(`DEVAD_PMA, 5'd7, `REG_CTRL, 1'b1, 16'h0800, v);
		check("bad_port", {12'h000, pwr}, 16'h0000);
		expect_reg(1'b1, 5'd0, 16'h8040, 16'h0000, "unmapped");
	endtask : refused

	initial begin
		repeat (100000) @(posedge clk_sys);
		error_cnt++;
		give_verdict;
	end

	initial begin
		repeat (5) @(negedge clk_sys);
		srst = 1'b0;
		@(negedge clk_sys);
		reset_values;
		control_bits;
		link_latch;
		fault_flag;
		ce_freeze;
		rate_words;
		vendor_words;
		refused;
		give_verdict;
	end
endmodule : tb_top
`default_nettype wire
